// ==== sim/mcfd_detector_monitor.sv ====
// port assertions for the clock failure detector
`timescale 1ns/100ps
`default_nettype none
module mcfd_detector_monitor
    import mcfd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_rc_clk,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic o_irq,
    input wire logic o_rc_osc_en,
    input wire logic o_fail_live_status,
    input wire logic [MCFD_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] o_rdata
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    wire st = i_rd && i_addr == MCFD_OFF_STATUS;
    wire cw = i_wr && i_addr == MCFD_OFF_OSC_CFG;
    a_reset_quiet: assert property ($past(i_sys_rst) |-> !o_rc_osc_en && !o_irq)
        else $error("active after reset");
    // config lands on the write edge, the rc enable copy one edge later
    a_enable_write: assert property (cw |=> ##1 (o_rc_osc_en == $past(i_wdata[2], 2)))
        else $error("rc enable wrong");
    a_off_live: assert property (cw && i_wdata[2:0] != 3'h7 |-> ##[1:3] !o_fail_live_status)
        else $error("live kept when off");
    a_irq_holds: assert property (o_irq && !i_rd && !i_wr && !$past(i_rd) && !$past(i_wr)
        |=> o_irq) else $error("irq dropped");
    sequence s_status_read;
        st && o_irq && !o_fail_live_status;
    endsequence
    // only a fresh failure, which also raises live status, may bring irq back
    sequence s_irq_gone;
        (!o_irq || o_fail_live_status) ##1 (!o_irq || o_fail_live_status);
    endsequence
    a_irq_read_clear: assert property (s_status_read |=> s_irq_gone)
        else $error("irq not cleared");
    a_live_read: assert property (st |=> o_rdata[1] == $past(o_fail_live_status))
        else $error("live read wrong");
    a_live_after_rc: assert property ($rose(o_fail_live_status) |-> !i_rc_clk && o_rc_osc_en)
        else $error("live rose early");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == MCFD_RD_ZERO)
        else $error("rdata not idle");
endmodule
bind mcfd_detector mcfd_detector_monitor u_mon (.i_sys_clk, .i_sys_rst, .i_rc_clk, .i_wr,
    .i_rd, .o_irq, .o_rc_osc_en, .o_fail_live_status, .i_addr, .i_wdata, .o_rdata);
`default_nettype wire

// ==== sim/mcfd_rc_model.sv ====
// slow rc oscillator model, runs only while enabled
`timescale 1ns/100ps
`default_nettype none
module mcfd_rc_model (
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [7:0] i_hi,
    output logic o_rc
);
    logic [7:0] n = 8'h00;
    initial o_rc = 1'b0;
    // stands low while disabled, high for i_hi cycles, then low for 21
    always @(posedge i_clk) begin
        n <= (!i_en || n == i_hi + 8'h14) ? 8'h00 : n + 8'h01;
        o_rc <= i_en && n < i_hi;
    end
endmodule
`default_nettype wire

// ==== sim/tb_mcfd_detector.sv ====
// testbench for the clock failure detector
`timescale 1ns/100ps
`default_nettype none
module tb_mcfd_detector
    import mcfd_pkg::*;
;
    logic clk = 0, rst = 1, wr = 0, rd = 0, rc, irq, en, live;
    logic [7:0] addr = 8'h00, hi = 8'h0c;
    logic [31:0] wdata = 32'h0, rdata;
    logic [2:0] cfg [3] = '{3'h6, 3'h5, 3'h3};
    int miscompares = 0, tests_run = 0;
    mcfd_detector dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_rc_clk(rc), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
        .o_rc_osc_en(en), .o_fail_live_status(live));
    mcfd_rc_model rcm (.i_clk(clk), .i_en(en), .i_hi(hi), .o_rc(rc));
    initial forever #25 clk = !clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk("rdata", e, rdata);
    endtask
    // waits n cycles, then compares {irq, live, rc enable}
    task automatic idle(input int n, input logic [2:0] e);
        repeat (n) @(posedge clk);
        #1;
        chk("irq_live_en", {29'h0, e}, {29'h0, irq, live, en});
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        idle(1, 3'h0);
        rd_chk(MCFD_OFF_OSC_CFG, 32'h0);
        rd_chk(8'h0c, 32'h0);
        acc(1'b1, MCFD_OFF_IRQ_MASK, 32'h1);
        acc(1'b1, MCFD_OFF_OSC_CFG, 32'h7);
        idle(100, 3'h1);
        hi = 8'h04;
        idle(100, 3'h7);
        hi = 8'h0c;
        idle(100, 3'h5);
        rd_chk(MCFD_OFF_STATUS, 32'h1);
        idle(2, 3'h1);
        acc(1'b1, MCFD_OFF_IRQ_MASK, 32'h0);
        hi = 8'h04;
        idle(100, 3'h3);
        rd_chk(MCFD_OFF_STATUS, 32'h3);
        foreach (cfg[i]) begin
            acc(1'b1, MCFD_OFF_OSC_CFG, {29'h0, cfg[i]});
            idle(100, {2'h0, cfg[i][2]});
        end
        // threshold edge: seven periods fail, eight pass
        hi <= 8'h07;
        acc(1'b1, MCFD_OFF_IRQ_MASK, 32'h1);
        acc(1'b1, MCFD_OFF_OSC_CFG, 32'h7);
        rd_chk(MCFD_OFF_OSC_CFG, 32'h7);
        rd_chk(MCFD_OFF_IRQ_MASK, 32'h1);
        idle(100, 3'h7);
        hi <= 8'h08;
        idle(100, 3'h5);
        // reset in mid-run drops the detector and the sticky flag
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        idle(1, 3'h0);
        rd_chk(MCFD_OFF_STATUS, 32'h0);
        rd_chk(MCFD_OFF_OSC_CFG, 32'h0);
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire

// ==== src/mcfd_detector.sv ====
// main clock failure detector with register port and interrupt
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - software enable bit in oscillator config register switches monitoring on or off
// - after core reset the detector stays disabled until software enables it
// - crystal oscillator enable at 0 forces the detector disabled
// - supervise the crystal only while it is selected as main clock
// - counter advances on main clock, evaluated by the slow rc clock
// - detector enable switches the slow rc oscillator on automatically
// - counter held clear while rc clock low, counts while high
// - fewer than eight main periods in one rc high phase is a failure
// - failure sets the sticky event flag and raises interrupt if enabled
// - interrupt stays asserted until the status register is read or the interrupt mask bit is written to 0
// - live failure status bit readable at any time
module mcfd_detector
    import mcfd_pkg::*;
#(
    parameter int MIN_PERIODS = MCFD_MIN_PERIODS
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_rc_clk,
    input wire logic [MCFD_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_rc_osc_en,
    output logic o_fail_live_status
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    mcfd_state_s s_q;
    mcfd_state_s s_d;
    mcfd_bus_s bus;
    logic active;
    logic rc_fall;
    logic fail;

    // counter is four bits wide and saturates at the threshold
    if (MIN_PERIODS < 1 || MIN_PERIODS > 15) begin : g_bad_min_periods
        $error("MIN_PERIODS must lie between 1 and 15");
    end

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        // detector runs only when enabled, crystal on and selected
        active = s_q.osc_cfg[MCFD_BIT_FD_EN] &&
            s_q.osc_cfg[MCFD_BIT_XTAL_EN] &&
            s_q.osc_cfg[MCFD_BIT_MAIN_SEL];

        // only the second and third stages are read by logic
        s_d.rc_meta = i_rc_clk;
        s_d.rc_sync = s_q.rc_meta;
        s_d.rc_prev = s_q.rc_sync;
        rc_fall = s_q.rc_prev && !s_q.rc_sync;

        // saturating counter: only needs to know whether eight were reached
        if (!s_q.rc_sync || !active) begin
            s_d.cnt = 4'h0;
        end else if (s_q.cnt != 4'(MIN_PERIODS)) begin
            s_d.cnt = s_q.cnt + 4'h1;
        end

        // a high phase ends at the falling edge; judge it there
        fail = active && rc_fall && (s_q.cnt < 4'(MIN_PERIODS));

        if (!active) begin
            s_d.live_status = 1'b0;
        end else if (rc_fall) begin
            s_d.live_status = fail;
        end

        s_d.rc_en = s_q.osc_cfg[MCFD_BIT_FD_EN];

        // register writes
        if (bus.wr) begin
            unique case (bus.addr)
                MCFD_OFF_OSC_CFG: s_d.osc_cfg = bus.wdata[2:0];
                MCFD_OFF_IRQ_MASK: s_d.irq_mask = bus.wdata[0];
                default: ;
            endcase
        end

        // register reads, one cycle later
        s_d.rdata = MCFD_RD_ZERO;
        if (bus.rd) begin
            unique case (bus.addr)
                MCFD_OFF_OSC_CFG: s_d.rdata[2:0] = s_q.osc_cfg;
                MCFD_OFF_STATUS: begin
                    s_d.rdata[MCFD_BIT_EVENT] = s_q.event_flag;
                    s_d.rdata[MCFD_BIT_LIVE] = s_q.live_status;
                end
                MCFD_OFF_IRQ_MASK: s_d.rdata[0] = s_q.irq_mask;
                default: ;
            endcase
        end

        // read clears the sticky flag, but a new failure wins
        if (bus.rd && bus.addr == MCFD_OFF_STATUS) begin
            s_d.event_flag = 1'b0;
        end
        if (fail) begin
            s_d.event_flag = 1'b1;
        end

        s_d.irq = s_d.event_flag && s_d.irq_mask;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.osc_cfg <= MCFD_RST_OSC_CFG;
            s_q.irq_mask <= MCFD_RST_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_irq = s_q.irq;
    assign o_rc_osc_en = s_q.rc_en;
    assign o_fail_live_status = s_q.live_status;

endmodule
`default_nettype wire

// ==== src/mcfd_pkg.sv ====
// package for the main clock failure detector: register map, fields, resets
`default_nettype none
package mcfd_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam int MCFD_ADDR_W = 8;
    localparam logic [7:0] MCFD_OFF_OSC_CFG = 8'h00;
    localparam logic [7:0] MCFD_OFF_STATUS = 8'h04;
    localparam logic [7:0] MCFD_OFF_IRQ_MASK = 8'h08;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int MCFD_BIT_XTAL_EN = 0;
    localparam int MCFD_BIT_MAIN_SEL = 1;
    localparam int MCFD_BIT_FD_EN = 2;
    localparam int MCFD_BIT_EVENT = 0;
    localparam int MCFD_BIT_LIVE = 1;

    // ----------------------------------------
    // reset values and counts
    // ----------------------------------------
    localparam logic [2:0] MCFD_RST_OSC_CFG = 3'h0;
    localparam logic MCFD_RST_MASK = 1'b0;
    localparam int MCFD_MIN_PERIODS = 8;
    localparam logic [31:0] MCFD_RD_ZERO = 32'h0000_0000;

    // ----------------------------------------
    // bundles
    // ----------------------------------------
    typedef struct packed {
        logic [MCFD_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mcfd_bus_s;

    typedef struct packed {
        logic [2:0] osc_cfg;
        logic irq_mask;
        logic event_flag;
        logic live_status;
        logic rc_meta;
        logic rc_sync;
        logic rc_prev;
        logic [3:0] cnt;
        logic [31:0] rdata;
        logic irq;
        logic rc_en;
    } mcfd_state_s;

endpackage
`default_nettype wire
